// ---- core/mode_select_pkg.sv ----
// constants for the mode and bank select register block
package mode_select_pkg;
   localparam int SR_W = 32;
   localparam logic [SR_W-1:0] SR_RESET = 32'h0000_0000;
   // field positions inside mode_and_bank_select
   localparam int AF_SHADOW_BIT = 0;
   localparam int LOCK_BIT = 1;
   localparam int IM_LO = 2;
   localparam int IM_HI = 3;
   localparam int IRQ_EN_BIT = 5;
   localparam int WIDE_BIT = 6;
   localparam int EXT_BIT = 7;
   localparam int TRIO_BIT = 8;
   localparam int MAIN_BANK_LO = 9;
   localparam int MAIN_BANK_HI = 10;
   localparam int IX_SHADOW_BIT = 16;
   localparam int IX_BANK_LO = 17;
   localparam int IX_BANK_HI = 18;
   localparam int IY_SHADOW_BIT = 24;
   localparam int IY_BANK_LO = 25;
   localparam int IY_BANK_HI = 26;
   // implemented bits; everything else is reserved and reads zero
   localparam logic [SR_W-1:0] SR_IMPL_MASK = 32'h0707_07ef;
   // selector for the set/clear control bit operations
   localparam logic [1:0] CB_EXT = 2'h0;
   localparam logic [1:0] CB_WIDE = 2'h1;
   localparam logic [1:0] CB_LOCK = 2'h2;
   // interrupt mode encodings
   localparam logic [1:0] IMODE_0 = 2'h0;
   // block counter / pointer step per iteration
   localparam logic [2:0] STEP_BYTE = 3'h1;
   localparam logic [2:0] STEP_WORD = 3'h2;
   localparam logic [2:0] STEP_LONG = 3'h4;
   // trap status bit positions
   localparam int TRAP_FETCH_BIT = 0;
   localparam int TRAP_ACK_BIT = 1;
endpackage : mode_select_pkg

// ---- core/mode_select_ctl.sv ----
// mode and bank select register with interrupt, trap and width control
module mode_select_ctl (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   input wire logic CTL_WR_I,
   input wire logic CTL_RD_I,
   input wire logic [mode_select_pkg::SR_W-1:0] CTL_WDATA_I,
   output logic [mode_select_pkg::SR_W-1:0] CTL_RDATA_O,
   output logic [mode_select_pkg::SR_W-1:0] SR_O,
   input wire logic SET_BIT_I,
   input wire logic CLR_BIT_I,
   input wire logic [1:0] BIT_SEL_I,
   input wire logic BANK_SWAP_I,
   input wire logic AF_SWAP_I,
   input wire logic IX_SWAP_I,
   input wire logic IY_SWAP_I,
   input wire logic IRQ_ON_I,
   input wire logic IRQ_OFF_I,
   input wire logic IM_WR_I,
   input wire logic [1:0] IM_VAL_I,
   input wire logic IRQ0_N_I,
   input wire logic INSTR_DONE_I,
   input wire logic BLOCK_ACTIVE_I,
   input wire logic ITER_DONE_I,
   output logic IRQ_TAKE_O,
   output logic STACK_OWN_ADDR_O,
   input wire logic UNDEF_FETCH_I,
   input wire logic ACK_UNDEF_I,
   input wire logic TRAP_CLR_I,
   output logic TRAP_O,
   output logic [1:0] TRAP_STATUS_O,
   input wire logic BUS_REQ_N_I,
   output logic BUS_ACK_N_O,
   input wire logic WORD_OP_I,
   input wire logic DECODER_DIRECTIVE_VALID_I,
   input wire logic DECODER_DIRECTIVE_LONG_I,
   output logic XFER_LONG_O,
   input wire logic BLOCK_WIDE_I,
   output logic [2:0] BLOCK_STEP_O,
   input wire logic LOAD8_OP_I,
   output logic FLAG_WE_O
);
   import mode_select_pkg::*;

   logic [SR_W-1:0] sr_q, sr_d;
   logic irq_meta_q, irq_sync_q;
   logic breq_meta_q, breq_sync_q;
   logic [1:0] trap_st_q, trap_st_d;
   logic [SR_W-1:0] wr_masked;
   logic set_ext, set_wide, clr_wide, set_lock, clr_lock;
   logic irq_pend, irq_point, irq_take, trap_fire, ack_trap;

   // pin synchronisers; only the second stage feeds logic
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         irq_meta_q <= 1'b0;
         irq_sync_q <= 1'b0;
         breq_meta_q <= 1'b0;
         breq_sync_q <= 1'b0;
      end else if (CE_I) begin
         irq_meta_q <= ~IRQ0_N_I;
         irq_sync_q <= irq_meta_q;
         breq_meta_q <= ~BUS_REQ_N_I;
         breq_sync_q <= breq_meta_q;
      end
   end

   // operation decodes
   assign wr_masked = CTL_WDATA_I & SR_IMPL_MASK;
   assign set_ext = SET_BIT_I && (BIT_SEL_I == CB_EXT);
   assign set_wide = SET_BIT_I && (BIT_SEL_I == CB_WIDE);
   assign clr_wide = CLR_BIT_I && (BIT_SEL_I == CB_WIDE);
   assign set_lock = SET_BIT_I && (BIT_SEL_I == CB_LOCK);
   assign clr_lock = CLR_BIT_I && (BIT_SEL_I == CB_LOCK);

   // interrupt acceptance point: instruction end, or end of a block iteration
   assign irq_pend = irq_sync_q && sr_q[IRQ_EN_BIT];
   assign irq_point = INSTR_DONE_I || (BLOCK_ACTIVE_I && ITER_DONE_I);
   assign irq_take = irq_pend && irq_point;

   // trap: undefined fetch, or undefined vector only in interrupt mode zero
   assign ack_trap = ACK_UNDEF_I && (sr_q[IM_HI:IM_LO] == IMODE_0);
   assign trap_fire = UNDEF_FETCH_I || ack_trap;

   // next select register value; a full control load applies first, then swaps and bit ops override it
   always_comb begin
      sr_d = sr_q;
      if (CTL_WR_I) begin
         sr_d = wr_masked;
         sr_d[EXT_BIT] = wr_masked[EXT_BIT] | sr_q[EXT_BIT];
      end
      if (BANK_SWAP_I) begin
         sr_d[TRIO_BIT] = ~sr_q[TRIO_BIT];
      end
      if (AF_SWAP_I) begin
         sr_d[AF_SHADOW_BIT] = ~sr_q[AF_SHADOW_BIT];
      end
      if (IX_SWAP_I) begin
         sr_d[IX_SHADOW_BIT] = ~sr_q[IX_SHADOW_BIT];
      end
      if (IY_SWAP_I) begin
         sr_d[IY_SHADOW_BIT] = ~sr_q[IY_SHADOW_BIT];
      end
      if (IM_WR_I) begin
         sr_d[IM_HI:IM_LO] = IM_VAL_I;
      end
      if (set_ext) begin
         sr_d[EXT_BIT] = 1'b1;
      end
      if (set_wide) begin
         sr_d[WIDE_BIT] = 1'b1;
      end else if (clr_wide) begin
         sr_d[WIDE_BIT] = 1'b0;
      end
      if (set_lock) begin
         sr_d[LOCK_BIT] = 1'b1;
      end else if (clr_lock) begin
         sr_d[LOCK_BIT] = 1'b0;
      end
      if (IRQ_ON_I) begin
         sr_d[IRQ_EN_BIT] = 1'b1;
      end else if (IRQ_OFF_I) begin
         sr_d[IRQ_EN_BIT] = 1'b0;
      end
      // acknowledge clears the enable last so a handler starts masked
      if (irq_take) begin
         sr_d[IRQ_EN_BIT] = 1'b0;
      end
   end

   // trap status: hardware set wins over a same-cycle clear
   always_comb begin
      trap_st_d = trap_st_q;
      if (TRAP_CLR_I) begin
         trap_st_d = 2'h0;
      end
      if (UNDEF_FETCH_I) begin
         trap_st_d[TRAP_FETCH_BIT] = 1'b1;
      end
      if (ack_trap) begin
         trap_st_d[TRAP_ACK_BIT] = 1'b1;
      end
   end

   // select register and status; bank fields reset to bank zero
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sr_q <= SR_RESET;
         trap_st_q <= 2'h0;
      end else if (CE_I) begin
         sr_q <= sr_d;
         trap_st_q <= trap_st_d;
      end
   end

   // registered outputs: read port, live select, status
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         CTL_RDATA_O <= SR_RESET;
         SR_O <= SR_RESET;
         TRAP_STATUS_O <= 2'h0;
      end else if (CE_I) begin
         if (CTL_RD_I) begin
            CTL_RDATA_O <= sr_q & SR_IMPL_MASK;
         end
         SR_O <= sr_d & SR_IMPL_MASK;
         TRAP_STATUS_O <= trap_st_d;
      end
   end

   // event outputs, one-cycle pulses; the stack address choice tells the
   // sequencer to push the block instruction's own address so it reruns
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         IRQ_TAKE_O <= 1'b0;
         STACK_OWN_ADDR_O <= 1'b0;
         TRAP_O <= 1'b0;
      end else if (CE_I) begin
         IRQ_TAKE_O <= irq_take;
         STACK_OWN_ADDR_O <= irq_take && BLOCK_ACTIVE_I && !INSTR_DONE_I;
         TRAP_O <= trap_fire;
      end
   end

   // bus grant is refused outright while locked, not queued
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         BUS_ACK_N_O <= 1'b1;
      end else if (CE_I) begin
         BUS_ACK_N_O <= ~(breq_sync_q && !sr_d[LOCK_BIT]);
      end
   end

   // transfer width, held until next word op; block step and flag write enable follow their inputs every cycle
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         XFER_LONG_O <= 1'b0;
         BLOCK_STEP_O <= STEP_BYTE;
         FLAG_WE_O <= 1'b0;
      end else if (CE_I) begin
         if (WORD_OP_I) begin
            XFER_LONG_O <= DECODER_DIRECTIVE_VALID_I ? DECODER_DIRECTIVE_LONG_I : sr_q[WIDE_BIT];
         end
         // counter steps by the unit size so a reissue resumes exactly
         if (!BLOCK_WIDE_I) begin
            BLOCK_STEP_O <= STEP_BYTE;
         end else begin
            BLOCK_STEP_O <= sr_q[WIDE_BIT] ? STEP_LONG : STEP_WORD;
         end
         FLAG_WE_O <= ~LOAD8_OP_I;
      end
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   a_ext_sticky: assert property (sr_q[EXT_BIT] |=> sr_q[EXT_BIT])
      else $error("extended mode flag cleared without reset");
   a_reserved_zero: assert property ((sr_q & ~SR_IMPL_MASK) == 32'h0
      && (CTL_RDATA_O & ~SR_IMPL_MASK) == 32'h0)
      else $error("reserved select bit read nonzero");
   a_ack_clears_en: assert property (CE_I && irq_take |=> !sr_q[IRQ_EN_BIT])
      else $error("irq enable not cleared on acknowledge");
   a_irq_only_en: assert property (CE_I && !sr_q[IRQ_EN_BIT] |=> !IRQ_TAKE_O)
      else $error("interrupt taken while disabled");
   a_irq_at_end: assert property (CE_I && !INSTR_DONE_I && !ITER_DONE_I
      |=> !IRQ_TAKE_O)
      else $error("interrupt taken mid instruction");
   a_lock_refuse: assert property (CE_I && sr_d[LOCK_BIT] |=> BUS_ACK_N_O)
      else $error("bus granted while locked");
   a_trap_fetch: assert property (CE_I && UNDEF_FETCH_I
      |=> TRAP_O && TRAP_STATUS_O[TRAP_FETCH_BIT])
      else $error("undefined fetch did not trap");
   a_trap_vector: assert property (CE_I && ACK_UNDEF_I && !UNDEF_FETCH_I
      |=> TRAP_O == (($past(sr_q[IM_HI:IM_LO])) == IMODE_0))
      else $error("vector trap mode mismatch");
   a_width_sel: assert property (CE_I && WORD_OP_I && DECODER_DIRECTIVE_VALID_I
      |=> XFER_LONG_O == $past(DECODER_DIRECTIVE_LONG_I))
      else $error("directive width ignored");
   a_trio_swap: assert property (CE_I && BANK_SWAP_I && !CTL_WR_I
      |=> sr_q[TRIO_BIT] != $past(sr_q[TRIO_BIT]))
      else $error("bank swap did not toggle trio select");
   a_flags_hold: assert property (CE_I && LOAD8_OP_I |=> !FLAG_WE_O)
      else $error("flags writable during byte load");
   a_block_own: assert property (STACK_OWN_ADDR_O |-> IRQ_TAKE_O)
      else $error("own address stacked without interrupt");

   // per-operation checks; each looks one edge after the request is taken
   a_ext_set_op: assert property (CE_I && set_ext
      |=> sr_q[EXT_BIT])
      else $error("set op did not raise extended flag");
   a_wide_set: assert property (CE_I && set_wide
      |=> sr_q[WIDE_BIT])
      else $error("wide bit not set");
   a_wide_clr: assert property (CE_I && clr_wide && !set_wide
      |=> !sr_q[WIDE_BIT])
      else $error("wide bit not cleared");
   a_lock_set: assert property (CE_I && set_lock
      |=> sr_q[LOCK_BIT])
      else $error("lock bit not set");
   a_bus_grant: assert property (CE_I && breq_sync_q && !sr_d[LOCK_BIT]
      |=> !BUS_ACK_N_O)
      else $error("bus not granted while unlocked");
   a_irq_on_set: assert property (CE_I && IRQ_ON_I && !irq_take
      |=> sr_q[IRQ_EN_BIT])
      else $error("irq enable not set");
   a_irq_off_clr: assert property (CE_I && IRQ_OFF_I && !IRQ_ON_I
      |=> !sr_q[IRQ_EN_BIT])
      else $error("irq enable not cleared");
   a_im_write: assert property (CE_I && IM_WR_I
      |=> sr_q[IM_HI:IM_LO] == $past(IM_VAL_I))
      else $error("interrupt mode not written");
   a_af_swap: assert property (CE_I && AF_SWAP_I && !CTL_WR_I
      |=> sr_q[AF_SHADOW_BIT] != $past(sr_q[AF_SHADOW_BIT]))
      else $error("accumulator shadow select not toggled");
   a_ix_swap: assert property (CE_I && IX_SWAP_I && !CTL_WR_I
      |=> sr_q[IX_SHADOW_BIT] != $past(sr_q[IX_SHADOW_BIT]))
      else $error("index x shadow select not toggled");
   a_iy_swap: assert property (CE_I && IY_SWAP_I && !CTL_WR_I
      |=> sr_q[IY_SHADOW_BIT] != $past(sr_q[IY_SHADOW_BIT]))
      else $error("index y shadow select not toggled");
   a_iy_bank_wr: assert property (CE_I && CTL_WR_I
      |=> sr_q[IY_BANK_HI:IY_BANK_LO] == $past(CTL_WDATA_I[IY_BANK_HI:IY_BANK_LO]))
      else $error("index y bank not written");
   a_ix_bank_wr: assert property (CE_I && CTL_WR_I
      |=> sr_q[IX_BANK_HI:IX_BANK_LO] == $past(CTL_WDATA_I[IX_BANK_HI:IX_BANK_LO]))
      else $error("index x bank not written");
   a_main_bank_wr: assert property (CE_I && CTL_WR_I
      |=> sr_q[MAIN_BANK_HI:MAIN_BANK_LO] == $past(CTL_WDATA_I[MAIN_BANK_HI:MAIN_BANK_LO]))
      else $error("primary bank not written");
   // a frozen clock enable must hold every field, not just the strobed ones
   a_ce_freeze: assert property (!CE_I
      |=> $stable(sr_q))
      else $error("select register moved while disabled");
   a_status_sticky: assert property (CE_I && trap_st_q[TRAP_FETCH_BIT] && !TRAP_CLR_I
      |=> trap_st_q[TRAP_FETCH_BIT])
      else $error("trap status lost without clear");
   a_ack_status: assert property (CE_I && ack_trap
      |=> TRAP_STATUS_O[TRAP_ACK_BIT])
      else $error("vector trap status not set");
   a_width_mode: assert property (CE_I && WORD_OP_I && !DECODER_DIRECTIVE_VALID_I
      |=> XFER_LONG_O == $past(sr_q[WIDE_BIT]))
      else $error("width does not follow mode bit");
   a_step_byte: assert property (CE_I && !BLOCK_WIDE_I
      |=> BLOCK_STEP_O == STEP_BYTE)
      else $error("byte block step wrong");
   a_flags_free: assert property (CE_I && !LOAD8_OP_I
      |=> FLAG_WE_O)
      else $error("flags blocked outside byte load");

   c_irq_taken: cover property (IRQ_TAKE_O);
   c_block_suspend: cover property (STACK_OWN_ADDR_O);
   c_trap_vector: cover property (TRAP_O && TRAP_STATUS_O[TRAP_ACK_BIT]);
   c_lock_refused: cover property (breq_sync_q && sr_q[LOCK_BIT] ##1 BUS_ACK_N_O);
   c_ext_mode: cover property (sr_q[EXT_BIT]);
endmodule : mode_select_ctl

// ---- bench/cpu_select_register_and_exceptions_tb.sv ----
// self-checking bench for the mode and bank select register block
module cpu_select_register_and_exceptions_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import mode_select_pkg::*;
   logic CLK_I, RST_I, CE_I, CTL_WR_I, CTL_RD_I, SET_BIT_I, CLR_BIT_I;
   logic BANK_SWAP_I, AF_SWAP_I, IX_SWAP_I, IY_SWAP_I, IRQ_ON_I, IRQ_OFF_I, IM_WR_I;
   logic IRQ0_N_I, INSTR_DONE_I, BLOCK_ACTIVE_I, ITER_DONE_I, UNDEF_FETCH_I, ACK_UNDEF_I;
   logic TRAP_CLR_I, BUS_REQ_N_I, WORD_OP_I, DECODER_DIRECTIVE_VALID_I, DECODER_DIRECTIVE_LONG_I, BLOCK_WIDE_I;
   logic LOAD8_OP_I, IRQ_TAKE_O, STACK_OWN_ADDR_O, TRAP_O, BUS_ACK_N_O, XFER_LONG_O, FLAG_WE_O;
   logic [1:0] BIT_SEL_I, IM_VAL_I, TRAP_STATUS_O;
   logic [2:0] BLOCK_STEP_O;
   logic [SR_W-1:0] CTL_WDATA_I, CTL_RDATA_O, SR_O;
   int err_count = 0;
   int compares = 0;
   int i;
   mode_select_ctl mode_select_ctl_inst (.*);
   // free-running core clock, 100 ns period
   initial begin
      CLK_I = 1'b0;
      forever #50 CLK_I = ~CLK_I;
   end
   task step(input int n = 1);
      repeat (n) @(negedge CLK_I);
   endtask : step
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task end_sim();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   // bounded wait for a registered output; running out counts as a mismatch
   task automatic wait_for(ref logic sig, input logic val);
      for (int k = 0; k < 8; k++) begin
         if (sig === val) return;
         step();
      end
      err_count++;
      $display("ERROR %0t: wait ran out", $time);
      end_sim();
   endtask : wait_for
   task wr(input logic [31:0] d);
      CTL_WR_I = 1'b1;
      CTL_WDATA_I = d;
      step();
      CTL_WR_I = 1'b0;
   endtask : wr
   task bitop(input logic set, input logic [1:0] sel);
      SET_BIT_I = set;
      CLR_BIT_I = ~set;
      BIT_SEL_I = sel;
      step();
      SET_BIT_I = 1'b0;
      CLR_BIT_I = 1'b0;
   endtask : bitop
   initial begin
      {CTL_WR_I, CTL_RD_I, SET_BIT_I, CLR_BIT_I, BANK_SWAP_I, AF_SWAP_I, IX_SWAP_I} = '0;
      {IY_SWAP_I, IRQ_ON_I, IRQ_OFF_I, IM_WR_I, INSTR_DONE_I, BLOCK_ACTIVE_I} = '0;
      {ITER_DONE_I, UNDEF_FETCH_I, ACK_UNDEF_I, TRAP_CLR_I, WORD_OP_I} = '0;
      {DECODER_DIRECTIVE_VALID_I, DECODER_DIRECTIVE_LONG_I, BLOCK_WIDE_I, LOAD8_OP_I, BIT_SEL_I, IM_VAL_I} = '0;
      CTL_WDATA_I = '0;
      CE_I = 1'b1;
      IRQ0_N_I = 1'b1;
      BUS_REQ_N_I = 1'b1;
      RST_I = 1'b1;
      step(10);
      chk(SR_O, SR_RESET);
      chk(BUS_ACK_N_O, 1'b1);
      RST_I = 1'b0;
      step(3);
      // reserved bits drop; extended flag is kept out of the plain write
      wr(32'hffff_ff7f);
      CTL_RD_I = 1'b1;
      step();
      CTL_RD_I = 1'b0;
      chk(CTL_RDATA_O, SR_IMPL_MASK & 32'hffff_ff7f);
      wr(32'h0);
      // each swap toggles only its own shadow select
      for (i = 0; i < 4; i++) begin
         {IY_SWAP_I, IX_SWAP_I, AF_SWAP_I, BANK_SWAP_I} = 4'h1 << i;
         step();
         {IY_SWAP_I, IX_SWAP_I, AF_SWAP_I, BANK_SWAP_I} = 4'h0;
         chk(SR_O, 32'h1 << (i == 0 ? TRIO_BIT : i == 1 ? AF_SHADOW_BIT : i == 2 ?
            IX_SHADOW_BIT : IY_SHADOW_BIT));
         wr(32'h0);
      end
      // bank fields are independent of each other
      wr(32'h0400_0000);
      chk(SR_O, 32'h0400_0000);
      wr(32'h0002_0400);
      chk(SR_O, 32'h0002_0400);
      // extended flag: raised by the set op here, then survives a zero write and the clear op
      bitop(1'b1, CB_EXT);
      chk(SR_O[EXT_BIT], 1'b1);
      wr(32'h0);
      chk(SR_O[EXT_BIT], 1'b1);
      bitop(1'b0, CB_EXT);
      chk(SR_O[EXT_BIT], 1'b1);
      for (i = 0; i < 4; i++) begin
         IM_WR_I = 1'b1;
         IM_VAL_I = i[1:0];
         step();
         IM_WR_I = 1'b0;
         chk(SR_O[IM_HI:IM_LO], i[1:0]);
      end
      // lock refuses the bus; unlocking grants within a few edges
      bitop(1'b1, CB_LOCK);
      BUS_REQ_N_I = 1'b0;
      step(5);
      chk(BUS_ACK_N_O, 1'b1);
      bitop(1'b0, CB_LOCK);
      wait_for(BUS_ACK_N_O, 1'b0);
      BUS_REQ_N_I = 1'b1;
      // pending request with enable clear must not be taken
      IRQ0_N_I = 1'b0;
      INSTR_DONE_I = 1'b1;
      step(4);
      chk(IRQ_TAKE_O, 1'b0);
      IRQ_ON_I = 1'b1;
      step();
      IRQ_ON_I = 1'b0;
      wait_for(IRQ_TAKE_O, 1'b1);
      chk(STACK_OWN_ADDR_O, 1'b0);
      chk(SR_O[IRQ_EN_BIT], 1'b0);
      INSTR_DONE_I = 1'b0;
      BLOCK_ACTIVE_I = 1'b1;
      IRQ_ON_I = 1'b1;
      step();
      IRQ_ON_I = 1'b0;
      step(2);
      chk(IRQ_TAKE_O, 1'b0);
      ITER_DONE_I = 1'b1;
      wait_for(IRQ_TAKE_O, 1'b1);
      chk(STACK_OWN_ADDR_O, 1'b1);
      {ITER_DONE_I, BLOCK_ACTIVE_I, IRQ0_N_I} = 3'b001;
      // vector trap only counts in mode zero; mode is three here
      ACK_UNDEF_I = 1'b1;
      step();
      ACK_UNDEF_I = 1'b0;
      step(2);
      chk(TRAP_STATUS_O, 2'h0);
      UNDEF_FETCH_I = 1'b1;
      step();
      UNDEF_FETCH_I = 1'b0;
      wait_for(TRAP_O, 1'b1);
      chk(TRAP_STATUS_O, 2'h1);
      IM_WR_I = 1'b1;
      IM_VAL_I = IMODE_0;
      step();
      {IM_WR_I, ACK_UNDEF_I} = 2'b01;
      step();
      ACK_UNDEF_I = 1'b0;
      wait_for(TRAP_O, 1'b1);
      chk(TRAP_STATUS_O, 2'h3);
      // width from mode bit, then overridden by a directive
      bitop(1'b1, CB_WIDE);
      chk(SR_O[WIDE_BIT], 1'b1);
      WORD_OP_I = 1'b1;
      step();
      chk(XFER_LONG_O, 1'b1);
      DECODER_DIRECTIVE_VALID_I = 1'b1;
      step();
      {WORD_OP_I, DECODER_DIRECTIVE_VALID_I} = 2'b00;
      chk(XFER_LONG_O, 1'b0);
      BLOCK_WIDE_I = 1'b1;
      step(2);
      chk(BLOCK_STEP_O, STEP_LONG);
      bitop(1'b0, CB_WIDE);
      step();
      chk(BLOCK_STEP_O, STEP_WORD);
      LOAD8_OP_I = 1'b1;
      step(2);
      chk(FLAG_WE_O, 1'b0);
      LOAD8_OP_I = 1'b0;
      step(2);
      chk(FLAG_WE_O, 1'b1);
      // status clear, then a set that beats a same-cycle clear
      TRAP_CLR_I = 1'b1;
      step();
      chk(TRAP_STATUS_O, 2'h0);
      UNDEF_FETCH_I = 1'b1;
      step();
      {TRAP_CLR_I, UNDEF_FETCH_I} = 2'b00;
      chk(TRAP_STATUS_O, 2'h1);
      // directive forces long while the mode bit says word
      WORD_OP_I = 1'b1;
      {DECODER_DIRECTIVE_VALID_I, DECODER_DIRECTIVE_LONG_I} = 2'b11;
      step();
      {WORD_OP_I, DECODER_DIRECTIVE_VALID_I, DECODER_DIRECTIVE_LONG_I} = 3'b000;
      chk(XFER_LONG_O, 1'b1);
      WORD_OP_I = 1'b1;
      step();
      WORD_OP_I = 1'b0;
      chk(XFER_LONG_O, 1'b0);
      // enable set by the on op, cleared by the off op
      IRQ_ON_I = 1'b1;
      step();
      chk(SR_O[IRQ_EN_BIT], 1'b1);
      {IRQ_ON_I, IRQ_OFF_I} = 2'b01;
      step();
      IRQ_OFF_I = 1'b0;
      chk(SR_O[IRQ_EN_BIT], 1'b0);
      // clock enable low freezes the register against a write
      CE_I = 1'b0;
      wr(32'h0000_0200);
      chk(SR_O, 32'h0000_0080);
      CE_I = 1'b1;
      // second reset in mid-run clears even the extended flag
      RST_I = 1'b1;
      step(2);
      chk(SR_O, SR_RESET);
      chk(BLOCK_STEP_O, STEP_BYTE);
      RST_I = 1'b0;
      step(2);
      wr(32'h0000_0001);
      chk(SR_O, 32'h0000_0001);
      end_sim();
   end
endmodule : cpu_select_register_and_exceptions_tb
